// File: logic/warn_pkg.sv
// constants, types and register map for the axis warning code generator
//==========================================================================
// Summary of operation
// R1 - every warning code sits at or above base
// R2 - amplifier warning code is amp number plus base
// R3 - program mode entry warns on every axis
// R4 - torque limit skipped during amp param/monitor
// R5 - start on busy axis raises duplicate startup
// R6 - busy axis rejects start and other requests; stop requests pass
// R7 - both jog contacts together: start wins, warn
// R8 - jog contact outside jog positioning warns
// R9 - sync difference over threshold warns when enabled
// R10 - movement check over threshold warns when enabled
// R11 - torque beyond limits warns when judged, warn mode
// R12 - speed beyond limits warns when judged, warn mode
// R13 - recalculation failure warns, good part continues
// R14 - latest code per axis held until host clears
//==========================================================================
package warn_pkg;
  localparam int NUM_AXES = 8;
  localparam int AXIS_W   = 3;

  // warning codes
  localparam logic [15:0] CODE_BASE      = 16'hA000;
  localparam logic [15:0] CODE_HOST_MODE = 16'hB001;
  localparam logic [15:0] CODE_RT_PROT   = 16'hB004;
  localparam logic [15:0] CODE_DUP_START = 16'hB010;
  localparam logic [15:0] CODE_JOG_BOTH  = 16'hB030;
  localparam logic [15:0] CODE_JOG_SPEED = 16'hB031;
  localparam logic [15:0] CODE_JOG_START = 16'hB032;
  localparam logic [15:0] CODE_SYNC_DIFF = 16'hB045;
  localparam logic [15:0] CODE_MOVE_CHK  = 16'hB046;
  localparam logic [15:0] CODE_TORQUE    = 16'hB050;
  localparam logic [15:0] CODE_SPEED     = 16'hB051;
  localparam logic [15:0] CODE_RECALC    = 16'hB304;
  localparam logic [15:0] CODE_NONE      = 16'h0000;
  localparam logic [11:0] AMP_NUM_MAX    = 12'hFFF;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MASK    = 8'h08;
  localparam logic [7:0] ADDR_CLEAR   = 8'h0C;
  localparam logic [7:0] ADDR_CODE0   = 8'h10;
  localparam logic [7:0] ADDR_CODE_HI = 8'h2C;

  // control register fields
  localparam int CTRL_SYNC_WARN = 0;
  localparam int CTRL_MOVE_WARN = 1;
  localparam int CTRL_TRQ_JUDGE = 2;
  localparam int CTRL_TRQ_WARN  = 3;
  localparam int CTRL_SPD_JUDGE = 4;
  localparam int CTRL_SPD_WARN  = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // per-axis event inputs from the motion engine
  typedef struct packed {
    logic        amp_warn;     // amplifier reported a warning
    logic [11:0] amp_num;      // amplifier warning number
    logic        start_req;    // start request
    logic        decel_stop;   // deceleration stop request
    logic        emerg_stop;   // emergency stop request
    logic        other_req;    // any other request
    logic        rt_trq_req;   // realtime torque limit request
    logic        jog_pos_act;  // jog positioning active
    logic        jog_speed;    // jog speed-change contact
    logic        jog_start;    // jog positioning-start contact
    logic        sync_over;    // sync difference over threshold
    logic        move_over;    // movement check over threshold
    logic        trq_over;     // torque beyond limits
    logic        spd_over;     // actual speed beyond limits
    logic        recalc_fail;  // recalculation failed
  } axis_evt_t;

  // per-axis command outputs
  typedef struct packed {
    logic accept_req;    // request allowed through
    logic accept_stop;   // stop request allowed through
    logic do_rt_trq;     // realtime torque limit executed
    logic do_jog_start;  // jog positioning start executed
    logic do_jog_speed;  // jog speed change executed
  } axis_cmd_t;
endpackage

// File: logic/axis_warn_unit.sv
// one axis: event priority and warning code selection
`timescale 1ns/1ps
module axis_warn_unit (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // inputs
  input  wire warn_pkg::axis_evt_t evt,
  input  wire logic               host_mode_evt,
  input  wire logic               amp_busy,
  input  wire logic               axis_busy,
  input  wire logic [5:0]         ctrl,
  // outputs
  output logic                    warn_pulse,
  output logic [15:0]             warn_code,
  output warn_pkg::axis_cmd_t     cmd
);
  logic        jog_both;
  logic        dup;
  logic        sync_w;
  logic        move_w;
  logic        trq_w;
  logic        spd_w;
  logic        rt_prot;
  logic [15:0] amp_code;
  logic [15:0] sel_code;

  // event detection
  assign jog_both = evt.jog_pos_act & evt.jog_speed & evt.jog_start; // R7
  assign dup      = evt.start_req & axis_busy; // R5
  assign rt_prot  = evt.rt_trq_req & amp_busy; // R4
  assign sync_w   = evt.sync_over & ctrl[warn_pkg::CTRL_SYNC_WARN]; // R9
  assign move_w   = evt.move_over & ctrl[warn_pkg::CTRL_MOVE_WARN]; // R10
  assign trq_w    = evt.trq_over & ctrl[warn_pkg::CTRL_TRQ_JUDGE]
                  & ctrl[warn_pkg::CTRL_TRQ_WARN]; // R11
  assign spd_w    = evt.spd_over & ctrl[warn_pkg::CTRL_SPD_JUDGE]
                  & ctrl[warn_pkg::CTRL_SPD_WARN]; // R12
  assign amp_code = warn_pkg::CODE_BASE + {4'h0, evt.amp_num}; // R1 R2

  // one code per cycle; earlier lines win when several fire together
  always_comb begin
    sel_code = warn_pkg::CODE_NONE;
    if (host_mode_evt) begin
      sel_code = warn_pkg::CODE_HOST_MODE; // R3
    end else if (dup) begin
      sel_code = warn_pkg::CODE_DUP_START;
    end else if (rt_prot) begin
      sel_code = warn_pkg::CODE_RT_PROT;
    end else if (jog_both) begin
      sel_code = warn_pkg::CODE_JOG_BOTH;
    end else if (evt.jog_speed && !evt.jog_pos_act) begin
      sel_code = warn_pkg::CODE_JOG_SPEED; // R8
    end else if (evt.jog_start && !evt.jog_pos_act) begin
      sel_code = warn_pkg::CODE_JOG_START; // R8
    end else if (sync_w) begin
      sel_code = warn_pkg::CODE_SYNC_DIFF;
    end else if (move_w) begin
      sel_code = warn_pkg::CODE_MOVE_CHK;
    end else if (trq_w) begin
      sel_code = warn_pkg::CODE_TORQUE;
    end else if (spd_w) begin
      sel_code = warn_pkg::CODE_SPEED;
    end else if (evt.recalc_fail) begin
      sel_code = warn_pkg::CODE_RECALC; // R13
    end else if (evt.amp_warn) begin
      sel_code = amp_code;
    end
  end

  // registered code, pulse and command gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_pulse <= 1'b0;
      warn_code  <= warn_pkg::CODE_NONE;
      cmd        <= '0;
    end else begin
      warn_pulse       <= (sel_code != warn_pkg::CODE_NONE);
      warn_code        <= sel_code;
      cmd.accept_req   <= (evt.start_req | evt.other_req) & ~axis_busy; // R6
      cmd.accept_stop  <= evt.decel_stop | evt.emerg_stop; // R6
      cmd.do_rt_trq    <= evt.rt_trq_req & ~amp_busy; // R4
      cmd.do_jog_start <= evt.jog_start & evt.jog_pos_act; // R7
      cmd.do_jog_speed <= evt.jog_speed & evt.jog_pos_act
                          & ~evt.jog_start; // R7
    end
  end
endmodule

// File: logic/axis_warning_code_generator.sv
// top: eight axis warning units behind an AXI4-Lite register slave
`timescale 1ns/1ps
module axis_warning_code_generator (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite write
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // system side
  input  wire logic                     program_operating_mode,
  input  wire logic                     amp_busy,
  input  wire logic [7:0]               axis_busy,
  input  wire warn_pkg::axis_evt_t [7:0] evt,
  output warn_pkg::axis_cmd_t [7:0]     cmd,
  output logic [7:0]                    warn_strobe,
  output logic                          irq
);
  logic [5:0]  ctrl_reg;
  logic [7:0]  status_reg;
  logic [7:0]  mask_reg;
  logic        program_operating_mode_d_reg;
  logic        host_evt;
  logic [15:0] code_reg [8];
  logic [7:0]  pulse;
  logic [15:0] ucode [8];
  logic [7:0]  clr_mask;
  logic [7:0]  w1c_mask;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        do_write;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] rd_data;
  logic [2:0]  rd_idx;
  logic [2:0]  wr_idx;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        aw_held_next;
  logic        w_held_next;
  logic        bvalid_next;
  logic        rvalid_next;
  logic        w_lane0_reg;

  // entry to program mode is one event for all axes
  assign host_evt = program_operating_mode & ~program_operating_mode_d_reg; // R3

  // per-axis units
  generate
    for (genvar i = 0; i < warn_pkg::NUM_AXES; i++) begin : g_axis
      axis_warn_unit u_axis (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .evt           (evt[i]),
        .host_mode_evt (host_evt),
        .amp_busy      (amp_busy),
        .axis_busy     (axis_busy[i]),
        .ctrl          (ctrl_reg),
        .warn_pulse    (pulse[i]),
        .warn_code     (ucode[i]),
        .cmd           (cmd[i])
      );
    end
  endgenerate

  // write path: address and data taken in either order
  assign aw_take      = s_axi_awvalid & s_axi_awready;
  assign w_take       = s_axi_wvalid & s_axi_wready;
  assign do_write     = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  // next values let the ready outputs come straight from flops
  assign aw_held_next = ~do_write & (aw_held_reg | aw_take);
  assign w_held_next  = ~do_write & (w_held_reg | w_take);
  assign bvalid_next  = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign wr_idx        = aw_addr_reg[4:2];
  assign wr_ok = (aw_addr_reg == warn_pkg::ADDR_CTRL)
              || (aw_addr_reg == warn_pkg::ADDR_STATUS)
              || (aw_addr_reg == warn_pkg::ADDR_MASK)
              || (aw_addr_reg == warn_pkg::ADDR_CLEAR);
  // byte lane 0 is latched with the data, not read live at the write
  assign w1c_mask = (do_write && aw_addr_reg == warn_pkg::ADDR_STATUS
                     && w_lane0_reg) ? w_data_reg[7:0] : 8'h00;
  assign clr_mask = (do_write && aw_addr_reg == warn_pkg::ADDR_CLEAR
                     && w_lane0_reg) ? w_data_reg[7:0] : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_lane0_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= warn_pkg::RESP_OKAY;
    end else begin
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      s_axi_awready <= ~aw_held_next & ~bvalid_next;
      s_axi_wready  <= ~w_held_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_ok ? warn_pkg::RESP_OKAY
                             : warn_pkg::RESP_SLVERR;
      end
    end
  end

  // control and mask registers, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= warn_pkg::CTRL_RESET;
      mask_reg <= 8'h00;
    end else if (do_write && w_lane0_reg) begin
      if (aw_addr_reg == warn_pkg::ADDR_CTRL) begin
        ctrl_reg <= w_data_reg[5:0];
      end
      if (aw_addr_reg == warn_pkg::ADDR_MASK) begin
        mask_reg <= w_data_reg[7:0];
      end
    end
  end

  // sticky status: a new warning beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 8'h00;
      program_operating_mode_d_reg <= 1'b0;
      irq        <= 1'b0;
      warn_strobe <= 8'h00;
    end else begin
      status_reg  <= (status_reg & ~w1c_mask) | pulse;
      program_operating_mode_d_reg  <= program_operating_mode;
      irq         <= |(((status_reg & ~w1c_mask) | pulse) & mask_reg);
      warn_strobe <= pulse;
    end
  end

  // latest code per axis, kept until the host clears it
  generate
    for (genvar i = 0; i < warn_pkg::NUM_AXES; i++) begin : g_code
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          code_reg[i] <= warn_pkg::CODE_NONE;
        end else if (pulse[i]) begin
          code_reg[i] <= ucode[i]; // R14
        end else if (clr_mask[i]) begin
          code_reg[i] <= warn_pkg::CODE_NONE; // R14
        end
      end
    end
  endgenerate

  // read decode
  assign ar_take     = s_axi_arvalid & s_axi_arready;
  assign rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign rd_idx = s_axi_araddr[4:2];
  assign rd_ok  = (s_axi_araddr == warn_pkg::ADDR_CTRL)
               || (s_axi_araddr == warn_pkg::ADDR_STATUS)
               || (s_axi_araddr == warn_pkg::ADDR_MASK)
               || (s_axi_araddr == warn_pkg::ADDR_CLEAR)
               || ((s_axi_araddr >= warn_pkg::ADDR_CODE0)
                   && (s_axi_araddr <= warn_pkg::ADDR_CODE_HI)
                   && (s_axi_araddr[1:0] == 2'b00));
  always_comb begin
    rd_data = 32'h0000_0000;
    case (s_axi_araddr)
      warn_pkg::ADDR_CTRL:   rd_data = {26'h0, ctrl_reg};
      warn_pkg::ADDR_STATUS: rd_data = {24'h0, status_reg};
      warn_pkg::ADDR_MASK:   rd_data = {24'h0, mask_reg};
      warn_pkg::ADDR_CLEAR:  rd_data = 32'h0000_0000;
      default: begin
        if (rd_ok) begin
          rd_data = {16'h0, code_reg[rd_idx - 3'h4]};
        end
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= warn_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
        s_axi_rresp <= rd_ok ? warn_pkg::RESP_OKAY
                             : warn_pkg::RESP_SLVERR;
      end
    end
  end
endmodule

// File: verif/axis_warning_code_generator_checker.sv
// port-level assertions for the axis warning code generator
`timescale 1ns/1ps
module axis_warning_code_generator_checker (
  // clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // register bus handshakes
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  // system side
  input wire logic                      program_operating_mode,
  input wire logic                      amp_busy,
  input wire logic [7:0]                axis_busy,
  input wire warn_pkg::axis_evt_t [7:0] evt,
  input wire warn_pkg::axis_cmd_t [7:0] cmd,
  input wire logic [7:0]                warn_strobe
);
  // ==================================================
  // one clock domain, so clocking and reset are shared
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a warning on axis 0 shows two edges after its cause
  sequence warn0_s;
    ##2 warn_strobe[0];
  endsequence
  // ==================================================
  // bus answers: on time, held until taken, no new write address while one is pending
  bvalid_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  rvalid_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped before rready");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  aw_refused_a:
    assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  // ==================================================
  // warning and acceptance relations
  host_warn_a:
    assert property ($rose(program_operating_mode) |-> ##2 &warn_strobe)
    else $error("program mode entry did not warn all axes");
  dup_warn_a:
    assert property (evt[0].start_req && axis_busy[0] |-> warn0_s)
    else $error("start on busy axis raised no warning");
  busy_reject_a:
    assert property (evt[0].start_req && axis_busy[0]
                     |=> !cmd[0].accept_req)
    else $error("start accepted on busy axis");
  stop_pass_a:
    assert property (evt[0].decel_stop || evt[0].emerg_stop
                     |=> cmd[0].accept_stop)
    else $error("stop request not passed");
  rt_skip_a:
    assert property (evt[0].rt_trq_req && amp_busy
                     |=> !cmd[0].do_rt_trq ##1 warn_strobe[0])
    else $error("torque limit ran during amplifier operation");
  jog_both_a:
    assert property (evt[0].jog_pos_act && evt[0].jog_speed &&
                     evt[0].jog_start |=> cmd[0].do_jog_start &&
                     !cmd[0].do_jog_speed)
    else $error("jog start did not win over speed change");
endmodule
bind axis_warning_code_generator axis_warning_code_generator_checker
  i_chk (.*);

// File: verif/motion_side_model.sv
// far-side model: motion engine raising one-cycle event pulses
`timescale 1ns/1ps
module motion_side_model (
  // clock
  input  wire logic                      aclk,
  // requests from the bench
  input  wire warn_pkg::axis_evt_t [7:0] req,
  input  wire logic                      go,
  // event pulses toward the generator
  output warn_pkg::axis_evt_t [7:0]      evt = '0
);
  // ==================================================
  // pulses last one cycle so each event counts once
  always @(posedge aclk) begin
    evt <= go ? req : '0;
  end
endmodule

// File: verif/axis_warning_code_generator_tb_top.sv
// self-checking bench for the axis warning code generator
`timescale 1ns/1ps
module axis_warning_code_generator_tb_top;
  // ==================================================
  // signals
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        program_operating_mode = 1'h0, amp_busy = 1'h0;
  logic        go = 1'h0;
  logic [7:0]  axis_busy = 8'h00, warn_strobe;
  warn_pkg::axis_evt_t [7:0] evt, req = '0;
  warn_pkg::axis_cmd_t [7:0] cmd;
  int          bad_count = 0, check_count = 0, seed = 22;

  axis_warning_code_generator i_dut (.*);
  motion_side_model i_far (.aclk(aclk), .req(req), .go(go), .evt(evt));

  // 100 ns period
  always #50 aclk = ~aclk;

  // ==================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one extra edge first so no signal is driven twice in a step
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] rsp);
    logic aw, w;
    @(posedge aclk);
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_awready) aw = 1'h0;
      if (s_axi_wready) w = 1'h0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(rsp));
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp,
                       input logic [1:0] rsp);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(rsp));
  endtask

  // ==================================================
  // expected values worked out from the event kind
  function automatic warn_pkg::axis_evt_t mk(int k, logic [11:0] n);
    warn_pkg::axis_evt_t e;
    e = '0;
    e.amp_warn = (k == 0);
    e.amp_num = n;
    e.start_req = (k == 1);
    e.decel_stop = (k == 1);
    e.rt_trq_req = (k == 2);
    e.jog_pos_act = (k == 3);
    e.jog_speed = (k == 3 || k == 4);
    e.jog_start = (k == 3 || k == 5);
    e.sync_over = (k == 6);
    e.move_over = (k == 7);
    e.trq_over = (k == 8);
    e.spd_over = (k == 9);
    e.recalc_fail = (k == 10);
    return e;
  endfunction

  function automatic logic [15:0] exp_code(int k, logic [11:0] n, int en);
    case (k)
      0: return 16'hA000 + {4'h0, n};
      1: return 16'hB010;
      2: return 16'hB004;
      3: return 16'hB030;
      4: return 16'hB031;
      5: return 16'hB032;
      6: return en ? 16'hB045 : 16'h0000;
      7: return en ? 16'hB046 : 16'h0000;
      8: return en ? 16'hB050 : 16'h0000;
      9: return en ? 16'hB051 : 16'h0000;
      10: return 16'hB304;
      default: return 16'hB001;
    endcase
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the run needs a few thousand cycles at most
  initial begin
    #(20000 * 100);
    bad_count++;
    report_and_stop();
  end

  // ==================================================
  // main sequence: reset values, then every event kind twice
  initial begin
    warn_pkg::axis_evt_t [7:0] v;
    logic [11:0] n;
    logic [15:0] c;
    logic [7:0]  s;
    logic [7:0]  ca;
    int          a;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      rdchk(8'(4 * i), 32'h0, 2'h0);
    end
    rdchk(warn_pkg::ADDR_CODE0, 32'h0, 2'h0);
    rdchk(8'h40, 32'h0, warn_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, warn_pkg::RESP_SLVERR);
    // lane 0 off: the control write must not land
    s_axi_wstrb <= 4'hE;
    wr(warn_pkg::ADDR_CTRL, 32'h3F, warn_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdchk(warn_pkg::ADDR_CTRL, 32'h0, 2'h0);
    for (int en = 0; en < 2; en++) begin
      for (int k = 0; k < 12; k++) begin
        a = (k < 4) ? 0 : $unsigned($random(seed)) % 8;
        n = 12'($random(seed));
        ca = warn_pkg::ADDR_CODE0 + 8'(4 * a);
        // judge bits alone must not warn: both bits are needed
        wr(warn_pkg::ADDR_CTRL, en ? 32'h3F : 32'h14, warn_pkg::RESP_OKAY);
        wr(warn_pkg::ADDR_MASK, en ? 32'hFF : 32'h0, warn_pkg::RESP_OKAY);
        rdchk(warn_pkg::ADDR_CTRL, en ? 32'h3F : 32'h14, 2'h0);
        v = '0;
        v[a] = mk(k, n);
        @(posedge aclk);
        axis_busy <= (k == 1) ? 8'h01 : 8'h00;
        amp_busy <= (k == 2);
        req <= v;
        go <= (k != 11);
        program_operating_mode <= (k == 11);
        @(posedge aclk);
        go <= 1'h0;
        repeat (5) @(posedge aclk);
        c = exp_code(k, n, en);
        s = (c == 16'h0) ? 8'h00 : (k == 11) ? 8'hFF : 8'(1 << a);
        // code stays readable until cleared
        rdchk(ca, {16'h0, c}, 2'h0);
        rdchk(warn_pkg::ADDR_STATUS, {24'h0, s}, 2'h0);
        chk(32'(irq), 32'(en != 0 && s != 8'h00));
        wr(warn_pkg::ADDR_STATUS, 32'hFF, warn_pkg::RESP_OKAY);
        wr(warn_pkg::ADDR_CLEAR, 32'hFF, warn_pkg::RESP_OKAY);
        rdchk(ca, 32'h0, 2'h0);
        rdchk(warn_pkg::ADDR_STATUS, 32'h0, 2'h0);
        chk(32'(irq), 32'h0);
        $display("case %0d enable %0d done", k, en);
      end
    end
    report_and_stop();
  end
endmodule
